// ### design/event_threshold_counter.sv
/*
  Event counter that pulses when its count reaches a programmed threshold.
  Assumes inc/clr are single-cycle strobes synchronous to hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module event_threshold_counter
  import notifier_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // counting
  input wire logic inc,
  input wire logic clr,
  input wire logic [CNT_W-1:0] thr,
  output logic hit
);

  logic [CNT_W-1:0] count;
  wire [CNT_W:0] count_plus = {1'b0, count} + {{CNT_W{1'b0}}, inc};

  // zero threshold disables; clear beats a coincident hit
  assign hit = inc && !clr && (thr != CNT_ZERO) && (count_plus == {1'b0, thr});

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= CNT_ZERO;
    end else if (clr || hit) begin
      count <= CNT_ZERO;
    end else begin
      count <= count_plus[CNT_W-1:0];
    end
  end

endmodule
`default_nettype wire

// ### design/multicast_vector_filter.sv
/*
  Combinational multicast egress vector builder.
  Assumes the group mask, bound mask and removed set are stable in the cycle used.
*/
`timescale 1ns/1ps
`default_nettype none
module multicast_vector_filter
  import notifier_pkg::*;
(
  // packet
  input wire logic [NUM_PORTS-1:0] group,
  input wire logic [PORT_W-1:0] ingress,
  // configuration
  input wire logic [NUM_PORTS-1:0] bound,
  input wire logic [NUM_PORTS-1:0] removed,
  // result
  output logic [NUM_PORTS-1:0] vector,
  output logic empty
);

  wire [NUM_PORTS-1:0] ingress_bit = port_onehot(ingress);

  // a removed port only loses its own copy
  assign vector = group & bound & ~removed & ~ingress_bit;
  assign empty = (vector == {NUM_PORTS{1'b0}});

endmodule
`default_nettype wire

// ### design/notifier_pkg.sv
/*
  Shared constants, field layout, carriers and helpers for the port event notifier.
  Assumes one core clock (hclk) and one asynchronous active-low reset.
*/
package notifier_pkg;

  // ============================================================
  // sizes
  localparam int NUM_PORTS = 4;
  localparam int PORT_W = 2;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int NSTAT = 12;
  localparam int NCNT = 5;

  // ============================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_INT_EN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PW_EN = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RETRY_THR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_EGR_THR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ING_THR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_RDR_THR = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MC_CTRL = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_REMOVED = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_ERR_THR = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_GSTAT = 8'h28;

  // ============================================================
  // status bit positions
  localparam int B_MAX_RETRY = 0;
  localparam int B_BAD_TRANS = 1;
  localparam int B_PARITY = 2;
  localparam int B_LINK_FAIL = 3;
  localparam int B_LINK_DEG = 4;
  localparam int B_RESET_REQ = 5;
  localparam int B_MC_SYMBOL = 6;
  localparam int B_EGR_CONG = 7;
  localparam int B_ING_CONG = 8;
  localparam int B_REORDER = 9;
  localparam int B_IMPL_ERR = 10;
  localparam int B_LAT_EXP = 11;

  // other field positions
  localparam int MC_AUTO_BIT = 0;
  localparam int MC_BIND_LSB = 8;
  localparam int ERR_FAIL_LSB = 0;
  localparam int ERR_DEG_LSB = 8;

  // counter slots
  localparam int C_RETRY = 0;
  localparam int C_SYM = 1;
  localparam int C_EGR = 2;
  localparam int C_ING = 3;
  localparam int C_RDR = 4;

  // ============================================================
  // values after reset and fixed constants
  localparam logic [NSTAT-1:0] RST_INT_EN = 12'h000;
  localparam logic [NSTAT-1:0] RST_PW_EN = 12'h000;
  localparam logic [NSTAT-1:0] PW_CAPABLE = 12'hf9f;
  localparam logic [CNT_W-1:0] RST_RETRY_THR = 16'h0010;
  localparam logic [CNT_W-1:0] RST_QUEUE_THR = 16'h0008;
  localparam logic [CNT_W-1:0] RST_RDR_THR = 16'hffff;
  localparam logic [CNT_W-1:0] RST_ERR_THR = 16'h0000;
  localparam logic [CNT_W-1:0] SYM_RUN_LEN = 16'h0004;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [NUM_PORTS-1:0] RST_MC_BIND = 4'h0;

  // ============================================================
  // carriers
  typedef struct packed {
    logic retry;
    logic pkt_accept;
    logic unmapped_route;
    logic reserved_tt;
    logic maint_hop_nonzero;
    logic parity_err;
    logic reset_req_sym;
    logic other_sym;
    logic mc_symbol;
    logic egress_exceed;
    logic ingress_exceed;
    logic reorder_inc;
    logic [7:0] err_rate;
    logic [NUM_PORTS-1:0] latency_expired;
  } event_in_t;

  typedef struct packed {
    logic valid;
    logic [NUM_PORTS-1:0] group;
    logic [PORT_W-1:0] ingress;
  } mc_pkt_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RD_WAIT = 2'b01,
    BUS_RD_DONE = 2'b11
  } bus_state_t;

  // ============================================================
  // helpers
  function automatic logic [NSTAT-1:0] sticky_next(input logic [NSTAT-1:0] cur,
      input logic [NSTAT-1:0] set, input logic [NSTAT-1:0] clr);
    sticky_next = (cur & ~clr) | set;
  endfunction

  function automatic logic [NUM_PORTS-1:0] port_onehot(input logic [PORT_W-1:0] idx);
    port_onehot = {NUM_PORTS{1'b0}};
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (idx == i[PORT_W-1:0]) begin
        port_onehot[i] = 1'b1;
      end
    end
  endfunction

endpackage

// ### design/switch_port_event_notifier.sv
/*
  Per-port event notifier: sticky status, interrupt and port-write request,
  event counters, multicast vector filtering and AHB-Lite register slave.
  Assumes event strobes are one-cycle pulses synchronous to hclk and that a
  single AHB-Lite master issues single word transfers.
*/
`timescale 1ns/1ps
`default_nettype none
module switch_port_event_notifier
  import notifier_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // port events
  input wire event_in_t ev,
  input wire logic port_reset,
  // multicast packets
  input wire mc_pkt_t mc_pkt,
  output logic mc_out_valid,
  output logic [NUM_PORTS-1:0] mc_egress,
  output logic mc_drop,
  output logic [NUM_PORTS-1:0] mc_purge,
  // notification
  output logic int_n,
  output logic pw_req,
  output logic [NSTAT-1:0] pw_cause
);

  // ============================================================
  // registers
  logic [NSTAT-1:0] status, gstat, int_en, pw_en;
  logic [CNT_W-1:0] retry_thr, egr_thr, ing_thr, rdr_thr, err_thr;
  logic mc_auto;
  logic [NUM_PORTS-1:0] mc_bind, removed;
  logic fail_ge_q, deg_ge_q;

  // ============================================================
  // bus front end
  bus_state_t state, next_state;
  logic wr_pend;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic rd_mapped;
  logic [31:0] rd_mux;

  wire take = hsel && hready && htrans[1];
  wire in_range = (haddr[31:ADDR_W] == 24'h000000);
  wire take_wr = take && hwrite && in_range;
  wire take_rd = take && !hwrite;

  // reads take one wait state so a write just before is seen
  assign hreadyout = (state != BUS_RD_WAIT);
  assign hresp = 1'b0;

  always_comb begin
    next_state = state;
    case (state)
      BUS_IDLE: begin
        if (take_rd) begin
          next_state = BUS_RD_WAIT;
        end
      end
      BUS_RD_WAIT: next_state = BUS_RD_DONE;
      BUS_RD_DONE: begin
        next_state = take_rd ? BUS_RD_WAIT : BUS_IDLE;
      end
      default: next_state = BUS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= BUS_IDLE;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
      rd_mapped <= 1'b0;
    end else begin
      state <= next_state;
      wr_pend <= take_wr;
      if (take) begin
        wr_addr <= haddr[ADDR_W-1:0];
        rd_addr <= haddr[ADDR_W-1:0];
        rd_mapped <= in_range;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (state == BUS_RD_WAIT) begin
      hrdata <= rd_mapped ? rd_mux : 32'h00000000;
    end
  end

  // unmapped offsets read as zero
  always_comb begin
    case (rd_addr)
      OFS_STATUS: rd_mux = {20'h00000, status};
      OFS_INT_EN: rd_mux = {20'h00000, int_en};
      OFS_PW_EN: rd_mux = {20'h00000, pw_en};
      OFS_RETRY_THR: rd_mux = {16'h0000, retry_thr};
      OFS_EGR_THR: rd_mux = {16'h0000, egr_thr};
      OFS_ING_THR: rd_mux = {16'h0000, ing_thr};
      OFS_RDR_THR: rd_mux = {16'h0000, rdr_thr};
      OFS_MC_CTRL: rd_mux = {20'h00000, mc_bind, 7'h00, mc_auto};
      OFS_REMOVED: rd_mux = {28'h0000000, removed};
      OFS_ERR_THR: rd_mux = {16'h0000, err_thr};
      OFS_GSTAT: rd_mux = {20'h00000, gstat};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ============================================================
  // write decode
  wire w_status = wr_pend && (wr_addr == OFS_STATUS);
  wire w_int_en = wr_pend && (wr_addr == OFS_INT_EN);
  wire w_pw_en = wr_pend && (wr_addr == OFS_PW_EN);
  wire w_retry = wr_pend && (wr_addr == OFS_RETRY_THR);
  wire w_egr = wr_pend && (wr_addr == OFS_EGR_THR);
  wire w_ing = wr_pend && (wr_addr == OFS_ING_THR);
  wire w_rdr = wr_pend && (wr_addr == OFS_RDR_THR);
  wire w_mc = wr_pend && (wr_addr == OFS_MC_CTRL);
  wire w_removed = wr_pend && (wr_addr == OFS_REMOVED);
  wire w_err = wr_pend && (wr_addr == OFS_ERR_THR);
  wire w_gstat = wr_pend && (wr_addr == OFS_GSTAT);

  wire [NSTAT-1:0] clr_status = w_status ? hwdata[NSTAT-1:0] : 12'h000;
  wire [NSTAT-1:0] clr_gstat = w_gstat ? hwdata[NSTAT-1:0] : 12'h000;
  wire [NUM_PORTS-1:0] clr_removed = w_removed ? hwdata[NUM_PORTS-1:0] : 4'h0;

  // ============================================================
  // event counters
  logic [NCNT-1:0] c_inc, c_clr, c_hit;
  logic [CNT_W-1:0] c_thr [NCNT];

  assign c_inc[C_RETRY] = ev.retry;
  assign c_inc[C_SYM] = ev.reset_req_sym;
  assign c_inc[C_EGR] = ev.egress_exceed;
  assign c_inc[C_ING] = ev.ingress_exceed;
  assign c_inc[C_RDR] = ev.reorder_inc;
  assign c_clr[C_RETRY] = ev.pkt_accept;
  assign c_clr[C_SYM] = ev.other_sym;
  assign c_clr[C_EGR] = 1'b0;
  assign c_clr[C_ING] = 1'b0;
  assign c_clr[C_RDR] = 1'b0;
  assign c_thr[C_RETRY] = retry_thr;
  assign c_thr[C_SYM] = SYM_RUN_LEN;
  assign c_thr[C_EGR] = egr_thr;
  assign c_thr[C_ING] = ing_thr;
  assign c_thr[C_RDR] = rdr_thr;

  // one shared retry counter, not one per packet
  for (genvar g = 0; g < NCNT; g++) begin : g_cnt
    event_threshold_counter u_cnt (
      .hclk(hclk),
      .hresetn(hresetn),
      .inc(c_inc[g]),
      .clr(c_clr[g]),
      .thr(c_thr[g]),
      .hit(c_hit[g])
    );
  end

  // ============================================================
  // error rate thresholds, zero disables
  wire [7:0] fail_thr = err_thr[ERR_FAIL_LSB +: 8];
  wire [7:0] deg_thr = err_thr[ERR_DEG_LSB +: 8];
  wire fail_ge = (fail_thr != 8'h00) && (ev.err_rate >= fail_thr);
  wire deg_ge = (deg_thr != 8'h00) && (ev.err_rate >= deg_thr);

  // ============================================================
  // event set vector; the implementation error bit is shared by retry limit, bad transaction and parity
  wire bad_trans = ev.unmapped_route || ev.reserved_tt || ev.maint_hop_nonzero;
  wire [NSTAT-1:0] set_vec = {
    |ev.latency_expired,
    c_hit[C_RETRY] | bad_trans | ev.parity_err,
    c_hit[C_RDR],
    c_hit[C_ING],
    c_hit[C_EGR],
    ev.mc_symbol,
    c_hit[C_SYM],
    deg_ge && !deg_ge_q,
    fail_ge && !fail_ge_q,
    ev.parity_err,
    bad_trans,
    c_hit[C_RETRY]
  };
  // symbol events never reach the port-write path
  wire [NSTAT-1:0] pw_set = set_vec & pw_en & PW_CAPABLE;
  wire [NSTAT-1:0] gset = set_vec & ((12'h001 << B_RESET_REQ) | (12'h001 << B_MC_SYMBOL));
  wire [NSTAT-1:0] next_status = sticky_next(status, set_vec, clr_status);

  // ============================================================
  // status, interrupt and port-write request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= 12'h000;
      gstat <= 12'h000;
      fail_ge_q <= 1'b0;
      deg_ge_q <= 1'b0;
      int_n <= 1'b1;
      pw_req <= 1'b0;
      pw_cause <= 12'h000;
    end else begin
      status <= next_status;
      gstat <= sticky_next(gstat, gset, clr_gstat);
      fail_ge_q <= fail_ge;
      deg_ge_q <= deg_ge;
      int_n <= ((next_status & int_en) == 12'h000);
      pw_req <= (pw_set != 12'h000);
      pw_cause <= pw_set;
    end
  end

  // ============================================================
  // configuration; port reset wins over software for pw_en, mc_auto, mc_bind and removed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_en <= RST_INT_EN;
      retry_thr <= RST_RETRY_THR;
      egr_thr <= RST_QUEUE_THR;
      ing_thr <= RST_QUEUE_THR;
      rdr_thr <= RST_RDR_THR;
      err_thr <= RST_ERR_THR;
    end else begin
      if (w_int_en) int_en <= hwdata[NSTAT-1:0];
      if (w_retry) retry_thr <= hwdata[CNT_W-1:0];
      if (w_egr) egr_thr <= hwdata[CNT_W-1:0];
      if (w_ing) ing_thr <= hwdata[CNT_W-1:0];
      if (w_rdr) rdr_thr <= hwdata[CNT_W-1:0];
      if (w_err) err_thr <= hwdata[CNT_W-1:0];
    end
  end

  wire [NUM_PORTS-1:0] remove_set = mc_auto ? ev.latency_expired : 4'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pw_en <= RST_PW_EN;
      mc_auto <= 1'b0;
      mc_bind <= RST_MC_BIND;
      removed <= 4'h0;
    end else if (port_reset) begin
      pw_en <= RST_PW_EN;
      mc_auto <= 1'b0;
      mc_bind <= RST_MC_BIND;
      removed <= 4'h0;
    end else begin
      if (w_pw_en) pw_en <= hwdata[NSTAT-1:0] & PW_CAPABLE;
      if (w_mc) mc_auto <= hwdata[MC_AUTO_BIT];
      if (w_mc) mc_bind <= hwdata[MC_BIND_LSB +: NUM_PORTS];
      removed <= (removed & ~clr_removed) | remove_set;
    end
  end

  // ============================================================
  // multicast filtering; port-writes do not take this path
  logic [NUM_PORTS-1:0] vec;
  logic vec_empty;

  multicast_vector_filter u_filter (
    .group(mc_pkt.group),
    .ingress(mc_pkt.ingress),
    .bound(mc_bind),
    .removed(removed),
    .vector(vec),
    .empty(vec_empty)
  );

  // a dropped packet leaves no trace in status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mc_out_valid <= 1'b0;
      mc_egress <= 4'h0;
      mc_drop <= 1'b0;
      mc_purge <= 4'h0;
    end else begin
      mc_out_valid <= mc_pkt.valid && !vec_empty;
      mc_egress <= mc_pkt.valid ? vec : 4'h0;
      mc_drop <= mc_pkt.valid && vec_empty;
      mc_purge <= ev.latency_expired;
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_int_low;
    ((status & int_en) != 12'h000) && !w_status && !w_int_en |=> !int_n;
  endproperty
  a_int_low: assert property (p_int_low) else $error("interrupt not asserted");
  // int_n follows the enable mask of the cycle before, so a mask write is excluded
  property p_int_high;
    ((status & int_en) == 12'h000) && !w_int_en ##1 ((status & int_en) == 12'h000) |-> int_n;
  endproperty
  a_int_high: assert property (p_int_high) else $error("interrupt stuck low");
  property p_retry;
    c_hit[C_RETRY] |=> status[B_MAX_RETRY] && status[B_IMPL_ERR];
  endproperty
  a_retry: assert property (p_retry) else $error("retry limit not flagged");
  property p_bad;
    ev.unmapped_route || ev.maint_hop_nonzero |=> status[B_BAD_TRANS] && status[B_IMPL_ERR];
  endproperty
  a_bad: assert property (p_bad) else $error("bad transaction not flagged");
  property p_parity;
    ev.parity_err |=> status[B_PARITY] && status[B_IMPL_ERR];
  endproperty
  a_parity: assert property (p_parity) else $error("parity not flagged");
  property p_sym_pw;
    !pw_cause[B_RESET_REQ] && !pw_cause[B_MC_SYMBOL];
  endproperty
  a_sym_pw: assert property (p_sym_pw) else $error("symbol event sent port-write");
  // a software clear inside the run may wipe a hit that came early in it
  property p_rst_req;
    (ev.reset_req_sym && !ev.other_sym && !w_status && !w_gstat) [*4]
      |=> status[B_RESET_REQ] && gstat[B_RESET_REQ];
  endproperty
  a_rst_req: assert property (p_rst_req) else $error("reset request run missed");
  property p_port_reset;
    port_reset |=> (pw_en == RST_PW_EN) && (mc_bind == RST_MC_BIND) && !mc_auto;
  endproperty
  a_port_reset: assert property (p_port_reset) else $error("port reset kept settings");
  property p_drop;
    mc_pkt.valid && ((mc_pkt.group & ~port_onehot(mc_pkt.ingress)) == 4'h0)
      |=> mc_drop && !mc_out_valid && ($stable(status) || $past(set_vec) != 12'h000);
  endproperty
  a_drop: assert property (p_drop) else $error("empty vector not dropped");
  property p_remove;
    mc_auto && !port_reset && (ev.latency_expired != 4'h0)
      |=> ((removed & $past(ev.latency_expired)) == $past(ev.latency_expired)) && (mc_purge != 4'h0);
  endproperty
  a_remove: assert property (p_remove) else $error("expired port not removed");

endmodule
`default_nettype wire

// ### sim/link_partner_model.sv
/*
  Far-side model: raises port event strobes and offers multicast packets.
  Assumes callers enter its tasks just after a rising edge of hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module link_partner_model
  import notifier_pkg::*;
(
  // clock
  input wire logic hclk,
  // far side traffic
  output var event_in_t ev,
  output var mc_pkt_t mc_pkt
);
  // ============================================================
  // traffic
  initial begin
    ev = '0;
    mc_pkt = '0;
  end

  // held n edges; a quiet edge follows so back-to-back calls never collide
  task automatic fire(input event_in_t e, input int n);
    ev <= e;
    repeat (n) @(posedge hclk);
    ev <= '0;
    @(posedge hclk);
  endtask

  task automatic send(input logic [NUM_PORTS-1:0] g, input logic [PORT_W-1:0] i);
    mc_pkt <= '{1'b1, g, i};
    @(posedge hclk);
    mc_pkt <= '0;
  endtask
endmodule
`default_nettype wire

// ### sim/tb_switch_port_event_notifier.sv
/*
  Self-checking bench for the port event notifier.
  Assumes the design answers an AHB-Lite master and a far-side model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_switch_port_event_notifier
  import notifier_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, port_reset;
  logic mc_out_valid, mc_drop, int_n, pw_req;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [NUM_PORTS-1:0] mc_egress, mc_purge;
  logic [NSTAT-1:0] pw_cause;
  event_in_t ev;
  mc_pkt_t mc_pkt;
  int n_fail = 0;
  int samples_checked = 0;

  switch_port_event_notifier i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ev(ev), .port_reset(port_reset),
    .mc_pkt(mc_pkt), .mc_out_valid(mc_out_valid), .mc_egress(mc_egress), .mc_drop(mc_drop),
    .mc_purge(mc_purge), .int_n(int_n), .pw_req(pw_req), .pw_cause(pw_cause));
  link_partner_model i_link (.hclk(hclk), .ev(ev), .mc_pkt(mc_pkt));

  // ============================================================
  // helpers
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // no cycle count assumed; a wait ends when hreadyout is high, bounded only by the watchdog
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask

  task automatic pk(input logic [3:0] g, input logic [1:0] i, input logic [3:0] e);
    i_link.send(g, i);
    @(posedge hclk);
    chk("mc", 32'({|e, ~|e, e}), 32'({mc_out_valid, mc_drop, mc_egress}));
  endtask

  // ============================================================
  // scenarios
  task automatic t_reset;
    rchk("int_en", OFS_INT_EN, 32'h0);
    rchk("pw_en", OFS_PW_EN, 32'h0);
    rchk("rdr_thr", OFS_RDR_THR, 32'h0000ffff);
    rchk("unmapped", 8'hfc, 32'h0);
    chk("idle", 32'h2, 32'({int_n, hresp}));
  endtask

  task automatic t_parity;
    event_in_t e;
    e = '0;
    e.parity_err = 1'b1;
    e.unmapped_route = 1'b1;
    wr(OFS_INT_EN, 32'hfff);
    wr(OFS_PW_EN, 32'hfff);
    i_link.fire(e, 1);
    chk("pw", 32'h1406, 32'({pw_req, pw_cause}));
    chk("int_n", 32'h0, 32'(int_n));
    wr(OFS_STATUS, 32'hfff);
    repeat (2) @(posedge hclk);
    chk("int_n off", 32'h1, 32'(int_n));
  endtask

  task automatic t_retry;
    event_in_t r, a;
    r = '0;
    r.retry = 1'b1;
    a = '0;
    a.pkt_accept = 1'b1;
    wr(OFS_RETRY_THR, 32'h3);
    i_link.fire(r, 2);
    i_link.fire(a, 1);
    i_link.fire(r, 2);
    rchk("retry clr", OFS_STATUS, 32'h0);
    i_link.fire(r, 1);
    rchk("retry hit", OFS_STATUS, 32'h401);
    wr(OFS_STATUS, 32'hfff);
  endtask

  task automatic t_symbols;
    event_in_t q, o, m;
    q = '0;
    q.reset_req_sym = 1'b1;
    o = '0;
    o.other_sym = 1'b1;
    m = '0;
    m.mc_symbol = 1'b1;
    i_link.fire(q, 3);
    i_link.fire(o, 1);
    i_link.fire(q, 3);
    rchk("run broken", OFS_STATUS, 32'h0);
    i_link.fire(o, 1);
    i_link.fire(q, 4);
    chk("no pw rst", 32'h0, 32'(pw_req));
    i_link.fire(m, 1);
    chk("no pw mcs", 32'h0, 32'(pw_req));
    rchk("status sym", OFS_STATUS, 32'h060);
    rchk("gstat", OFS_GSTAT, 32'h060);
    wr(OFS_STATUS, 32'hfff);
    wr(OFS_GSTAT, 32'hfff);
  endtask

  task automatic t_queues;
    event_in_t e;
    e = '0;
    e.egress_exceed = 1'b1;
    e.ingress_exceed = 1'b1;
    e.reorder_inc = 1'b1;
    wr(OFS_EGR_THR, 32'h2);
    wr(OFS_ING_THR, 32'h2);
    wr(OFS_RDR_THR, 32'h2);
    i_link.fire(e, 1);
    rchk("queue one", OFS_STATUS, 32'h0);
    i_link.fire(e, 1);
    rchk("queue two", OFS_STATUS, 32'h380);
    wr(OFS_STATUS, 32'hfff);
  endtask

  task automatic t_rate;
    event_in_t e;
    e = '0;
    wr(OFS_ERR_THR, 32'h0609);
    e.err_rate = 8'h06;
    i_link.fire(e, 1);
    rchk("degraded", OFS_STATUS, 32'h010);
    e.err_rate = 8'h09;
    i_link.fire(e, 1);
    rchk("failed", OFS_STATUS, 32'h018);
    wr(OFS_STATUS, 32'hfff);
  endtask

  task automatic t_mcast;
    event_in_t e;
    e = '0;
    e.latency_expired = 4'h4;
    wr(OFS_MC_CTRL, 32'hf01);
    pk(4'h3, 2'd0, 4'h2);
    pk(4'h1, 2'd0, 4'h0);
    pk(4'h0, 2'd1, 4'h0);
    rchk("drop silent", OFS_STATUS, 32'h0);
    i_link.fire(e, 1);
    chk("purge", 32'h4, 32'(mc_purge));
    rchk("removed", OFS_REMOVED, 32'h4);
    pk(4'he, 2'd1, 4'h8);
    port_reset <= 1'b1;
    @(posedge hclk);
    port_reset <= 1'b0;
    rchk("mc_ctrl", OFS_MC_CTRL, 32'h0);
    rchk("pw_en", OFS_PW_EN, 32'h0);
    pk(4'h3, 2'd0, 4'h0);
    wr(OFS_MC_CTRL, 32'hf00);
    pk(4'h3, 2'd0, 4'h2);
  endtask

  // ============================================================
  // run
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // whole run is about 150 cycles; this is far beyond it
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    complete_run;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    port_reset = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_parity;
    t_retry;
    t_symbols;
    t_queues;
    t_rate;
    t_mcast;
    complete_run;
  end
endmodule
`default_nettype wire
